// ==== core/overtravel_limit_handler.sv ====
`timescale 1ns/1ps
module overtravel_limit_handler
    import ot_limit_pkg::*;
(
    input wire logic sys_clk, // 20 MHz control clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic forward_limit_input, // Forward limit switch, high = allowed
    input wire logic reverse_limit_input, // Reverse limit switch, high = allowed
    input wire logic error_clear_input, // Host clear of position error
    input wire logic [3:0] forward_limit_config, // Forward limit digit
    input wire logic [3:0] reverse_limit_config, // Reverse limit digit
    input wire logic [7:0] overtravel_stop_select, // Stop select low two digits
    input wire logic [9:0] emergency_stop_force, // Stop force, percent rated
    input wire logic [9:0] motor_max_force, // Motor peak force, percent rated
    input wire logic [3:0] overtravel_warning_enable, // Warning enable digit
    input wire logic motor_power_on, // Servo power on
    input wire logic force_control, // Force control mode active
    input wire logic position_control, // Position control mode active
    input wire logic ref_fwd, // Forward reference requested
    input wire logic ref_rev, // Reverse reference requested
    input wire logic motor_stopped, // Motor speed at zero
    input wire logic brake_release_request, // Normal brake release from sequencer
    output logic fwd_overtravel, // Forward overtravel active
    output logic rev_overtravel, // Reverse overtravel active
    output logic allow_fwd, // Forward reference passed
    output logic allow_rev, // Reverse reference passed
    output logic brake_active, // Short-circuit braking applied
    output logic decel_active, // Deceleration stop running
    output logic [9:0] applied_stop_force, // Force used for deceleration
    output logic zero_clamp, // Position loop at zero reference
    output logic baseblock, // Motor drive cut off
    output logic hold_position_error, // Position error retained
    output logic brake_release_output, // Holding brake released
    output logic [11:0] overtravel_warning_code // Warning code, zero when none
);

    // ****************************************
    // Helpers
    // ****************************************
    // Two synchronised samples agree
    function automatic logic agreed(input logic a, input logic b);
        return a == b;
    endfunction : agreed

    function automatic logic [9:0] min_force(input logic [9:0] a, input logic [9:0] b);
        return (a < b) ? a : b;
    endfunction : min_force

    // Rising level between the previous and the present cycle
    function automatic logic rose_now(input logic cur, input logic prev);
        return cur && !prev;
    endfunction : rose_now

    // Short-circuit braking or coasting, by the low digit of the stop select
    function automatic stop_state_type plain_stop(input logic [3:0] low);
        return (low == STOP_COAST_THEN_COAST) ? ST_COAST : ST_BRAKE;
    endfunction : plain_stop

    // ****************************************
    // Limit input synchronisers
    // ****************************************
    logic [2:0] fwd_sync_ff;
    logic [2:0] rev_sync_ff;
    logic fwd_ok_ff;
    logic rev_ok_ff;
    logic pwr_ff;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fwd_sync_ff <= 3'h7;
            rev_sync_ff <= 3'h7;
            fwd_ok_ff <= 1'b1;
            rev_ok_ff <= 1'b1;
        end else begin
            fwd_sync_ff <= {fwd_sync_ff[1:0], forward_limit_input};
            rev_sync_ff <= {rev_sync_ff[1:0], reverse_limit_input};
            if (agreed(fwd_sync_ff[1], fwd_sync_ff[2])) begin
                fwd_ok_ff <= fwd_sync_ff[2];
            end
            if (agreed(rev_sync_ff[1], rev_sync_ff[2])) begin
                rev_ok_ff <= rev_sync_ff[2];
            end
        end
    end

    logic cfg_loaded_ff;
    logic fwd_ign_cfg_ff;
    logic rev_ign_cfg_ff;

    // First cycle after reset release latches the config digits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_loaded_ff <= 1'b0;
            fwd_ign_cfg_ff <= 1'b0;
            rev_ign_cfg_ff <= 1'b0;
        end else if (!cfg_loaded_ff) begin
            cfg_loaded_ff <= 1'b1;
            fwd_ign_cfg_ff <= (forward_limit_config == FWD_LIMIT_IGNORED);
            rev_ign_cfg_ff <= (reverse_limit_config == REV_LIMIT_IGNORED);
        end
    end

    logic fwd_ot;
    logic rev_ot;
    assign fwd_ot = !fwd_ign_cfg_ff && !fwd_ok_ff;
    assign rev_ot = !rev_ign_cfg_ff && !rev_ok_ff;

    // ****************************************
    // Stop sequencer
    // ****************************************
    stop_state_type state_ff;
    stop_state_type nxt_state;
    logic [3:0] stop_low;
    logic [3:0] stop_mid;
    logic ot_toward;
    assign stop_low = overtravel_stop_select[3:0];
    assign stop_mid = overtravel_stop_select[7:4];
    // Overtravel that blocks the current motion
    assign ot_toward = (fwd_ot && ref_fwd) || (rev_ot && ref_rev) ||
                       ((fwd_ot || rev_ot) && !ref_fwd && !ref_rev);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (ot_toward && motor_power_on) begin
                    if (stop_mid != STOP_DECEL_NONE && !force_control) begin
                        nxt_state = ST_DECEL;
                    end else begin
                        nxt_state = plain_stop(stop_low);
                    end
                end
            end
            ST_BRAKE, ST_COAST: begin
                if (motor_stopped) begin
                    nxt_state = ST_STOPPED;
                end
            end
            // Force mode arriving mid-stop drops deceleration for the plain stop
            ST_DECEL: begin
                if (motor_stopped) begin
                    nxt_state = ST_STOPPED;
                end else if (force_control) begin
                    nxt_state = plain_stop(stop_low);
                end
            end
            ST_STOPPED: begin
                if (!fwd_ot && !rev_ot) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    // Sequencer state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= ST_RUN;
        end else if (!motor_power_on) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Drive outputs
    // ****************************************
    logic clamp_sel;
    // Zero clamp only for decel code 1 outside force control
    assign clamp_sel = (stop_mid == STOP_DECEL_CLAMP) && !force_control;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fwd_overtravel <= 1'b0;
            rev_overtravel <= 1'b0;
            allow_fwd <= 1'b0;
            allow_rev <= 1'b0;
            brake_active <= 1'b0;
            decel_active <= 1'b0;
            applied_stop_force <= 10'h000;
            zero_clamp <= 1'b0;
            baseblock <= 1'b0;
            brake_release_output <= 1'b0;
        end else begin
            fwd_overtravel <= fwd_ot;
            rev_overtravel <= rev_ot;
            allow_fwd <= ref_fwd && !fwd_ot;
            allow_rev <= ref_rev && !rev_ot;
            // Code 00 keeps braking once stopped, 01 lets go; force mode lets go once stopped
            brake_active <= (nxt_state == ST_BRAKE) ||
                (nxt_state == ST_STOPPED && stop_low == STOP_BRAKE_THEN_BRAKE &&
                 stop_mid == STOP_DECEL_NONE && !force_control);
            decel_active <= (nxt_state == ST_DECEL);
            applied_stop_force <= min_force(min_force(emergency_stop_force, ESTOP_FORCE_MAX),
                                            motor_max_force);
            zero_clamp <= (nxt_state == ST_STOPPED) && clamp_sel;
            baseblock <= (nxt_state == ST_STOPPED) && !clamp_sel;
            brake_release_output <= brake_release_request ||
                (motor_power_on && (fwd_ot || rev_ot));
        end
    end

    // Error retained from an overtravel stop until the host clears it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_position_error <= 1'b0;
        end else if (position_control && state_ff != ST_RUN) begin
            hold_position_error <= 1'b1;
        end else if (error_clear_input) begin
            hold_position_error <= 1'b0;
        end
    end

    // ****************************************
    // Overtravel warning
    // ****************************************
    logic fwd_ot_d_ff;
    logic rev_ot_d_ff;
    logic [24:0] hold_cnt_ff;
    logic warn_on_ff;
    logic warn_event;
    logic warn_en;
    assign warn_en = (overtravel_warning_enable == WARN_ENABLED);

    // Previous overtravel and power levels for edge detection
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fwd_ot_d_ff <= 1'b0;
            rev_ot_d_ff <= 1'b0;
            pwr_ff <= 1'b0;
        end else begin
            fwd_ot_d_ff <= fwd_ot;
            rev_ot_d_ff <= rev_ot;
            pwr_ff <= motor_power_on;
        end
    end

    // New overtravel while powered; a power-on edge alone never fires
    assign warn_event = warn_en && motor_power_on && pwr_ff &&
        ((rose_now(fwd_ot, fwd_ot_d_ff) && !ref_rev) ||
         (rose_now(rev_ot, rev_ot_d_ff) && !ref_fwd));

    // Latched warning, held one second after overtravel clears
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            warn_on_ff <= 1'b0;
            hold_cnt_ff <= 25'h0000000;
        end else if (warn_event) begin
            warn_on_ff <= 1'b1;
            hold_cnt_ff <= 25'h0000000;
        end else if (!warn_en) begin
            warn_on_ff <= 1'b0;
        end else if (warn_on_ff && (fwd_ot || rev_ot)) begin
            hold_cnt_ff <= 25'h0000000;
        end else if (warn_on_ff) begin
            if (hold_cnt_ff == 25'(WARN_HOLD_CYC - 1)) begin
                warn_on_ff <= 1'b0;
                hold_cnt_ff <= 25'h0000000;
            end else begin
                hold_cnt_ff <= hold_cnt_ff + 25'h0000001;
            end
        end
    end

    // Report only; no path back into motion logic
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            overtravel_warning_code <= NO_WARNING_CODE;
        end else begin
            overtravel_warning_code <= (warn_on_ff || warn_event) ? OT_WARNING_CODE
                                                                  : NO_WARNING_CODE;
        end
    end

endmodule : overtravel_limit_handler

// ==== include/ot_limit_pkg.sv ====
package ot_limit_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int WARN_HOLD_MS = 1000;
    localparam int WARN_HOLD_CYC = CLK_HZ / 1000 * WARN_HOLD_MS;

    // ****************************************
    // Limit configuration digit codes
    // ****************************************
    localparam logic [3:0] FWD_LIMIT_FROM_PIN = 4'h2;
    localparam logic [3:0] FWD_LIMIT_IGNORED = 4'h8;
    localparam logic [3:0] REV_LIMIT_FROM_PIN = 4'h3;
    localparam logic [3:0] REV_LIMIT_IGNORED = 4'h8;

    // ****************************************
    // Stop select field, low digit and second digit
    // ****************************************
    localparam logic [3:0] STOP_BRAKE_THEN_BRAKE = 4'h0;
    localparam logic [3:0] STOP_BRAKE_THEN_COAST = 4'h1;
    localparam logic [3:0] STOP_COAST_THEN_COAST = 4'h2;
    localparam logic [3:0] STOP_DECEL_NONE = 4'h0;
    localparam logic [3:0] STOP_DECEL_CLAMP = 4'h1;
    localparam logic [3:0] STOP_DECEL_COAST = 4'h2;
    localparam logic [7:0] STOP_SELECT_RESET = 8'h00;

    // ****************************************
    // Force settings, percent of rated force
    // ****************************************
    localparam logic [9:0] ESTOP_FORCE_MAX = 10'h320;
    localparam logic [9:0] ESTOP_FORCE_RESET = 10'h320;

    // ****************************************
    // Warning enable digit codes and warning code
    // ****************************************
    localparam logic [3:0] WARN_DISABLED = 4'h0;
    localparam logic [3:0] WARN_ENABLED = 4'h1;
    localparam logic [11:0] OT_WARNING_CODE = 12'h9A0;
    localparam logic [11:0] NO_WARNING_CODE = 12'h000;

    // ****************************************
    // Overtravel stop sequencer
    // ****************************************
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_BRAKE = 5'b00010,
        ST_COAST = 5'b00100,
        ST_DECEL = 5'b01000,
        ST_STOPPED = 5'b10000
    } stop_state_type;

endpackage : ot_limit_pkg

// ==== testbench/limit_switch_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Normally closed limit switches, open when struck
// ****************************************
module limit_switch_model (
    input wire logic trip_fwd, // Forward switch struck
    input wire logic trip_rev, // Reverse switch struck
    output logic forward_limit_input, // High while allowed
    output logic reverse_limit_input // High while allowed
);
    // Contacts change asynchronously to the drive clock
    assign forward_limit_input = !trip_fwd;
    assign reverse_limit_input = !trip_rev;
endmodule : limit_switch_model

// ==== testbench/ot_limit_props.sv ====
`timescale 1ns/1ps
// ****************************************
// Port-level checks of the overtravel handler
// ****************************************
module ot_limit_props
    import ot_limit_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic srst, // Reset
    input wire logic error_clear_input, // Error clear
    input wire logic [9:0] motor_max_force, // Motor peak
    input wire logic [3:0] overtravel_warning_enable, // Warning enable
    input wire logic motor_power_on, // Power
    input wire logic force_control, // Force mode
    input wire logic ref_rev, // Reverse ref
    input wire logic fwd_overtravel, // Fwd overtravel
    input wire logic rev_overtravel, // Rev overtravel
    input wire logic allow_fwd, // Fwd pass
    input wire logic allow_rev, // Rev pass
    input wire logic decel_active, // Decel stop
    input wire logic [9:0] applied_stop_force, // Stop force
    input wire logic zero_clamp, // Clamp
    input wire logic baseblock, // Drive cut
    input wire logic hold_position_error, // Error held
    input wire logic [11:0] overtravel_warning_code // Warning
);
    localparam int HOLD_MIN = WARN_HOLD_CYC - 4;
    logic warn;
    logic [24:0] quiet_ff;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    assign warn = overtravel_warning_code == OT_WARNING_CODE;
    // Cycles since overtravel was last shown
    always_ff @(posedge sys_clk) begin
        if (srst || fwd_overtravel || rev_overtravel) quiet_ff <= '0;
        else if (quiet_ff != '1) quiet_ff <= quiet_ff + 25'h1;
    end
    property p_fwd_block;
        fwd_overtravel && $past(fwd_overtravel) |-> !allow_fwd;
    endproperty
    a_fwd_block: assert property (p_fwd_block) else $error("forward passed in overtravel");
    property p_rev_block;
        rev_overtravel && $past(rev_overtravel) |-> !allow_rev;
    endproperty
    a_rev_block: assert property (p_rev_block) else $error("reverse passed in overtravel");
    property p_away;
        fwd_overtravel && !rev_overtravel && $past(!rev_overtravel && ref_rev) |-> allow_rev;
    endproperty
    a_away: assert property (p_away) else $error("move away refused");
    property p_warn_enable;
        $rose(warn) |-> $past(overtravel_warning_enable) == WARN_ENABLED;
    endproperty
    a_warn_enable: assert property (p_warn_enable) else $error("warning while disabled");
    property p_warn_power;
        $rose(warn) |-> $past(motor_power_on);
    endproperty
    a_warn_power: assert property (p_warn_power) else $error("warning with power off");
    property p_warn_hold;
        $fell(warn) && overtravel_warning_enable == WARN_ENABLED |-> quiet_ff >= HOLD_MIN;
    endproperty
    a_warn_hold: assert property (p_warn_hold) else $error("warning cleared early");
    property p_no_decel;
        force_control && $past(force_control) |-> !decel_active;
    endproperty
    a_no_decel: assert property (p_no_decel) else $error("decel in force mode");
    property p_clamp;
        zero_clamp |-> !baseblock;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp with drive cut");
    property p_force;
        decel_active |-> applied_stop_force <= ESTOP_FORCE_MAX
            && applied_stop_force <= $past(motor_max_force);
    endproperty
    a_force: assert property (p_force) else $error("stop force above limit");
    property p_err_hold;
        $past(hold_position_error && !error_clear_input) |-> hold_position_error;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error hold lost");
    c_decel: cover property (decel_active);
    c_warn: cover property ($rose(warn));
    c_clamp: cover property (zero_clamp);
endmodule : ot_limit_props

bind overtravel_limit_handler ot_limit_props u_ot_limit_props (.*);

// ==== testbench/overtravel_limit_handler_bench.sv ====
`timescale 1ns/1ps
module overtravel_limit_handler_bench
    import ot_limit_pkg::*;
;
    logic sys_clk = 1'b0, srst = 1'b1, error_clear_input = 1'b0, motor_power_on = 1'b1;
    logic force_control = 1'b0, position_control = 1'b1, ref_fwd = 1'b0, ref_rev = 1'b0;
    logic motor_stopped = 1'b0, brake_release_request = 1'b0, trip_fwd = 1'b0, trip_rev = 1'b0;
    logic [3:0] forward_limit_config = FWD_LIMIT_FROM_PIN, reverse_limit_config = REV_LIMIT_FROM_PIN;
    logic [3:0] overtravel_warning_enable = WARN_ENABLED;
    logic [7:0] overtravel_stop_select = STOP_SELECT_RESET;
    logic [9:0] emergency_stop_force = ESTOP_FORCE_RESET, motor_max_force = 10'h12C, fe;
    logic forward_limit_input, reverse_limit_input, fwd_overtravel, rev_overtravel;
    logic allow_fwd, allow_rev, brake_active, decel_active, zero_clamp, baseblock;
    logic hold_position_error, brake_release_output;
    logic [9:0] applied_stop_force;
    logic [11:0] overtravel_warning_code;
    logic [31:0] exp_q[$], msk_q[$], obs, e, m, seed = 32'h0000EE41;
    logic [7:0] code_t[5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20};
    logic [5:0] res_t[5] = '{6'b101001, 6'b100001, 6'b000001, 6'b010010, 6'b010001};
    int fails = 0, checks = 0, cyc = 0, i;
    event look;
    overtravel_limit_handler u_overtravel_limit_handler (.*);
    limit_switch_model u_limit_switch_model (.*);
    assign obs = {fwd_overtravel, rev_overtravel, allow_fwd, allow_rev, brake_active,
        decel_active, zero_clamp, baseblock, hold_position_error, brake_release_output,
        applied_stop_force, overtravel_warning_code};
    // ****************************************
    // Clock, timeout, scoreboard
    // ****************************************
    initial begin
        forever #25 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        forever begin
            @(look);
            #1;
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            checks++;
            if (((obs ^ e) & m) !== 32'h0) begin
                fails++;
                $display("wrong value at %0t: got %h expected %h", $time, obs & m, e & m);
            end
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic note(input logic [9:0] f, input logic [9:0] fm,
        input logic [11:0] w = 12'h000, input logic wm = 1'b0,
        input logic [9:0] fv = 10'h000, input logic fvm = 1'b0);
        exp_q.push_back({f, fv, w});
        msk_q.push_back({fm, {10{fvm}}, {12{wm}}});
        -> look;
    endtask : note
    task automatic restart();
        {trip_fwd, trip_rev, ref_fwd, ref_rev, motor_stopped} = 5'b0;
        motor_power_on = 1'b1;
        srst = 1'b1;
        tick(8);
        srst = 1'b0;
        tick(2);
    endtask : restart
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // ****************************************
    // Scenarios; flags: fot rot afw arv brk dec clp bb hold brel
    // ****************************************
    initial begin
        restart();
        ref_fwd = 1'b1;
        trip_fwd = 1'b1;
        tick(10);
        note(10'b1000100011, 10'b1111110011, OT_WARNING_CODE, 1'b1);
        ref_fwd = 1'b0;
        ref_rev = 1'b1;
        tick(3);
        note(10'b1001000000, 10'b1111000000);
        motor_stopped = 1'b1;
        tick(3);
        note(10'b1001100111, 10'b1000111111);
        trip_fwd = 1'b0;
        tick(8);
        note(10'b0000000000, 10'b1000000000, OT_WARNING_CODE, 1'b1);
        error_clear_input = 1'b1;
        tick(2);
        error_clear_input = 1'b0;
        note(10'b0000000000, 10'b0000000011);
        $display("test forward overtravel finished");
        restart();
        ref_fwd = 1'b1;
        trip_rev = 1'b1;
        tick(8);
        note(10'b0110000000, 10'b1110000000, NO_WARNING_CODE, 1'b1);
        restart();
        trip_rev = 1'b1;
        tick(8);
        note(10'b0100000000, 10'b0100000000, OT_WARNING_CODE, 1'b1);
        restart();
        motor_power_on = 1'b0;
        trip_fwd = 1'b1;
        tick(8);
        note(10'b1000000000, 10'b1000000000, NO_WARNING_CODE, 1'b1);
        motor_power_on = 1'b1;
        tick(8);
        note(10'b1000000000, 10'b1000000000, NO_WARNING_CODE, 1'b1);
        overtravel_warning_enable = WARN_DISABLED;
        restart();
        trip_fwd = 1'b1;
        tick(8);
        note(10'b1000000000, 10'b1000000000, NO_WARNING_CODE, 1'b1);
        overtravel_warning_enable = WARN_ENABLED;
        restart();
        trip_fwd = 1'b1;
        tick(3);
        trip_fwd = 1'b0;
        tick(8);
        note(10'b0000000000, 10'b1000000000, OT_WARNING_CODE, 1'b1);
        $display("test warning finished");
        forward_limit_config = FWD_LIMIT_IGNORED;
        reverse_limit_config = REV_LIMIT_IGNORED;
        restart();
        forward_limit_config = FWD_LIMIT_FROM_PIN;
        reverse_limit_config = REV_LIMIT_FROM_PIN;
        {ref_fwd, ref_rev, trip_fwd, trip_rev} = 4'hF;
        tick(8);
        note(10'b0011000000, 10'b1111000000, NO_WARNING_CODE, 1'b1);
        $display("test limit config finished");
        for (i = 0; i < 5; i++) begin
            seed = xs(seed);
            emergency_stop_force = 10'(seed % 801);
            seed = xs(seed);
            motor_max_force = 10'(seed % 801);
            fe = (emergency_stop_force < motor_max_force) ? emergency_stop_force : motor_max_force;
            overtravel_stop_select = code_t[i];
            restart();
            ref_fwd = 1'b1;
            trip_fwd = 1'b1;
            tick(8);
            note({4'b0, res_t[i][5:4], 4'b0}, 10'b0000110000, 12'h0, 1'b0, fe, res_t[i][4]);
            motor_stopped = 1'b1;
            tick(4);
            note({4'b0, res_t[i][3:0], 2'b0}, 10'b0000111100);
        end
        $display("test stop methods finished");
        overtravel_stop_select = 8'h10;
        force_control = 1'b1;
        position_control = 1'b0;
        restart();
        ref_fwd = 1'b1;
        trip_fwd = 1'b1;
        tick(8);
        note(10'b0000100000, 10'b0000110000);
        motor_stopped = 1'b1;
        tick(4);
        note(10'b0000000100, 10'b0000111100);
        force_control = 1'b0;
        restart();
        ref_fwd = 1'b1;
        trip_fwd = 1'b1;
        tick(8);
        note(10'b0000010000, 10'b0000110000);
        force_control = 1'b1;
        tick(3);
        note(10'b0000100000, 10'b0000110000);
        $display("test force control finished");
        tick(2);
        final_report();
    end
endmodule : overtravel_limit_handler_bench
